// File: logic/adsc_pkg.sv
/*
  Constants for the actuator diagnostic reporting and return-spring check block.
  Assumes a 20 MHz system clock and an APB register port with 32-bit data.
*/
package adsc_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  // timing
  localparam int unsigned START_TIMEOUT_MS = 200;
  localparam int unsigned START_TIMEOUT_CYC = START_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_START_POS = 12'h004;
  localparam logic [11:0] OFS_FINISH_POS = 12'h008;
  localparam logic [11:0] OFS_FINISH_TMO = 12'h00c;
  localparam logic [11:0] OFS_SPRING_STAT = 12'h010;
  localparam logic [11:0] OFS_DIAG = 12'h014;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h018;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h01c;
  // control fields
  localparam int CTRL_SPRING_EN = 0;
  // reset values
  localparam logic [7:0] START_POS_RST = 8'hc0;
  localparam logic [7:0] FINISH_POS_RST = 8'h10;
  localparam logic [15:0] FINISH_TMO_RST = 16'h01f4;
  // data substitutions and temperature thresholds
  localparam logic [7:0] DATA_NOT_AVAIL = 8'hfe;
  localparam logic signed [9:0] TEMP_SHUTOFF = 10'sd125;
  localparam logic signed [9:0] TEMP_DERATE = 10'sd118;
  localparam logic signed [9:0] TEMP_LOW = -10'sd40;
  // failure mode codes
  localparam logic [4:0] FMI_OVERTEMP = 5'h00;
  localparam logic [4:0] FMI_POS_ERR = 5'h07;
  localparam logic [4:0] FMI_TSENSE_FAIL = 5'h0c;
  localparam logic [4:0] FMI_DEMAND_LOST = 5'h0e;
  localparam logic [4:0] FMI_DERATE = 5'h0f;
  localparam logic [4:0] FMI_CAN_RANGE = 5'h10;
  localparam logic [4:0] FMI_NORMAL = 5'h1f;
  // temperature status codes
  localparam logic [2:0] TST_IN_RANGE = 3'h0;
  localparam logic [2:0] TST_HIGH_LEAST = 3'h1;
  localparam logic [2:0] TST_HIGH_MOST = 3'h2;
  localparam logic [2:0] TST_LOW_LEAST = 3'h3;
  localparam logic [2:0] TST_ERROR = 3'h4;
  // spring check result codes
  localparam logic [1:0] SPR_PENDING = 2'h0;
  localparam logic [1:0] SPR_PASSED = 2'h1;
  localparam logic [1:0] SPR_FAILED = 2'h2;
  localparam logic [1:0] SPR_NOT_DONE = 2'h3;
  // interrupt bits
  localparam int IRQ_SPRING_DONE = 0;
  localparam int IRQ_SPRING_FAIL = 1;
  localparam int IRQ_OVERTEMP = 2;
  localparam int IRQ_CLAIM_FAIL = 3;
  localparam int IRQ_W = 4;

  typedef enum logic [5:0] {
    SPR_IDLE = 6'b000001,
    SPR_DRIVE = 6'b000010,
    SPR_LIMP = 6'b000100,
    SPR_DONE_OK = 6'b001000,
    SPR_DONE_BAD = 6'b010000,
    SPR_ABORTED = 6'b100000
  } adsc_spr_e;
endpackage

// File: logic/adsc_top.sv
/*
  Diagnostic indication mapping and power-up return-spring check.
  Assumes all inputs synchronous to mclk, an APB master, and that the
  position loop reports arrival at the commanded position through pos_fb.
*/
// The placing of the registers and the APB slave port were left to the implementer.
// Summary of operation
// - spring check runs only when the enable control bit is set
// - once position control is active, shaft is commanded to start position
// - at start position, timer starts and drive current is forced to zero
// - not reaching start within 200 ms raises the spring check fault
// - not reaching finish before configured timeout raises the spring fault
// - reaching finish in time sets spring status to passed
// - valid demand or shutdown before completion abandons check as not performed
// - all demand sources failed: desired position 0xfe, failure code 14
// - temperature sensor failed: temperature 0xfe, status error, code 12
// - temperature at or above 125: zero current, high most severe, code 0
// - temperature at or above 118: derate flag, high least severe, code 15
// - temperature below -40: low temperature flag, low least severe
// - failed analog or pulse demand: report the demand value in use
// - CAN demand out of range: report demand in use, code 16
// - position error: report actual position, code 7
// - address claim failure sets status bit and zeroes CAN demand
`timescale 1ns/1ps
`default_nettype none
module adsc_top
  import adsc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // position loop
  input wire logic pos_ctrl_active,
  input wire logic [7:0] pos_fb,
  input wire logic [7:0] demand_in_use,
  input wire logic demand_valid,
  input wire logic forced_stop_state,
  output logic spring_cmd_active,
  output logic [7:0] spring_cmd_pos,
  output logic drive_zero,
  // diagnostic conditions
  input wire logic demand_all_failed,
  input wire logic analog_fail_high,
  input wire logic analog_fail_low,
  input wire logic pwm_fail_high,
  input wire logic pwm_fail_low,
  input wire logic can_demand_out_of_range,
  input wire logic pos_error,
  input wire logic temp_sensor_failed,
  input wire logic signed [9:0] temp_sensed,
  input wire logic addr_claim_failed,
  input wire logic [7:0] can_demand_raw,
  // can diagnostic indications
  output logic [7:0] rpt_desired_pos,
  output logic [7:0] rpt_pos_fb,
  output logic [7:0] rpt_temp,
  output logic [2:0] rpt_temp_status,
  output logic [4:0] rpt_fmi,
  output logic derate_flag,
  output logic temp_low_flag,
  output logic spring_fault,
  output logic claim_fail_status,
  output logic [7:0] can_demand_eff,
  // interrupt
  output logic irq
);
  import adsc_pkg::*;

  logic spring_en_reg;
  logic [7:0] start_pos_reg;
  logic [7:0] finish_pos_reg;
  logic [15:0] finish_tmo_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_event;
  adsc_spr_e spr_reg;
  adsc_spr_e spr_next;
  logic [1:0] spr_result;
  logic [22:0] tmr_reg;
  logic [15:0] ms_tmr_reg;
  logic [14:0] ms_div_reg;
  logic ms_tick;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] temp_byte;
  logic overtemp;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      OFS_CTRL, OFS_START_POS, OFS_FINISH_POS, OFS_FINISH_TMO,
      OFS_SPRING_STAT, OFS_DIAG, OFS_IRQ_STAT, OFS_IRQ_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  // configuration registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      spring_en_reg <= 1'b0;
      start_pos_reg <= START_POS_RST;
      finish_pos_reg <= FINISH_POS_RST;
      finish_tmo_reg <= FINISH_TMO_RST;
      irq_mask_reg <= '0;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL: spring_en_reg <= pwdata[CTRL_SPRING_EN];
        OFS_START_POS: start_pos_reg <= pwdata[7:0];
        OFS_FINISH_POS: finish_pos_reg <= pwdata[7:0];
        OFS_FINISH_TMO: finish_tmo_reg <= pwdata[15:0];
        OFS_IRQ_MASK: irq_mask_reg <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // read data is registered so it stands until the next read
  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_CTRL: prdata <= {31'h0, spring_en_reg};
        OFS_START_POS: prdata <= {24'h0, start_pos_reg};
        OFS_FINISH_POS: prdata <= {24'h0, finish_pos_reg};
        OFS_FINISH_TMO: prdata <= {16'h0, finish_tmo_reg};
        OFS_SPRING_STAT: prdata <= {30'h0, spr_result};
        OFS_DIAG: prdata <= {12'h0, claim_fail_status, spring_fault, temp_low_flag,
                             derate_flag, rpt_temp_status, rpt_fmi, rpt_temp};
        OFS_IRQ_STAT: prdata <= {28'h0, irq_stat_reg};
        OFS_IRQ_MASK: prdata <= {28'h0, irq_mask_reg};
        default: prdata <= '0;
      endcase
    end
  end

  // millisecond enable for the finish timeout
  assign ms_tick = (ms_div_reg == 15'(MS_CYC - 1));
  always_ff @(posedge mclk) begin
    if (srst || ms_tick || spr_reg != SPR_LIMP) begin
      ms_div_reg <= '0;
    end else begin
      ms_div_reg <= ms_div_reg + 15'h1;
    end
  end

  // spring check sequencer; the idle state is left once only, so the
  // final state holds until the next power-up reset
  always_comb begin
    spr_next = spr_reg;
    case (spr_reg)
      SPR_IDLE: begin
        if (spring_en_reg && pos_ctrl_active) begin
          spr_next = SPR_DRIVE;
        end
      end
      SPR_DRIVE: begin
        if (demand_valid || forced_stop_state) begin
          spr_next = SPR_ABORTED;
        end else if (pos_fb == start_pos_reg) begin
          spr_next = SPR_LIMP;
        end else if (tmr_reg == 23'(START_TIMEOUT_CYC - 1)) begin
          spr_next = SPR_DONE_BAD;
        end
      end
      SPR_LIMP: begin
        if (demand_valid || forced_stop_state) begin
          spr_next = SPR_ABORTED;
        end else if (pos_fb == finish_pos_reg) begin
          spr_next = SPR_DONE_OK;
        end else if (ms_tick && ms_tmr_reg + 16'h1 >= finish_tmo_reg) begin
          spr_next = SPR_DONE_BAD;
        end
      end
      SPR_DONE_OK, SPR_DONE_BAD, SPR_ABORTED: spr_next = spr_reg;
      default: spr_next = SPR_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      spr_reg <= SPR_IDLE;
    end else begin
      spr_reg <= spr_next;
    end
  end

  // start-phase cycle timer and finish-phase millisecond timer
  always_ff @(posedge mclk) begin
    if (srst || spr_reg != SPR_DRIVE) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_reg + 23'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || spr_reg != SPR_LIMP) begin
      ms_tmr_reg <= '0;
    end else if (ms_tick) begin
      ms_tmr_reg <= ms_tmr_reg + 16'h1;
    end
  end

  always_comb begin
    case (spr_reg)
      SPR_DONE_OK: spr_result = SPR_PASSED;
      SPR_DONE_BAD: spr_result = SPR_FAILED;
      SPR_ABORTED: spr_result = SPR_NOT_DONE;
      default: spr_result = SPR_PENDING;
    endcase
  end

  assign spring_cmd_active = (spr_reg == SPR_DRIVE);
  assign spring_cmd_pos = start_pos_reg;
  assign overtemp = !temp_sensor_failed && (temp_sensed >= TEMP_SHUTOFF);
  // limp phase and overtemperature both cut drive current
  assign drive_zero = (spr_reg == SPR_LIMP) || overtemp;
  assign spring_fault = (spr_reg == SPR_DONE_BAD);
  assign claim_fail_status = addr_claim_failed;
  assign can_demand_eff = addr_claim_failed ? 8'h00 : can_demand_raw;

  assign temp_byte = temp_sensed[7:0];

  // diagnostic indications; temperature shutdown outranks derating, and
  // the code order gives the most severe condition the failure code
  always_ff @(posedge mclk) begin
    if (srst) begin
      rpt_desired_pos <= '0;
      rpt_pos_fb <= '0;
      rpt_temp <= '0;
      rpt_temp_status <= TST_IN_RANGE;
      rpt_fmi <= FMI_NORMAL;
      derate_flag <= 1'b0;
      temp_low_flag <= 1'b0;
    end else begin
      // analog, pulse-width and CAN failures keep the value in use
      rpt_desired_pos <= demand_all_failed ? DATA_NOT_AVAIL : demand_in_use;
      rpt_pos_fb <= pos_fb;
      derate_flag <= !temp_sensor_failed && temp_sensed >= TEMP_DERATE;
      temp_low_flag <= !temp_sensor_failed && temp_sensed < TEMP_LOW;
      if (temp_sensor_failed) begin
        rpt_temp <= DATA_NOT_AVAIL;
        rpt_temp_status <= TST_ERROR;
      end else begin
        rpt_temp <= temp_byte;
        if (temp_sensed >= TEMP_SHUTOFF) begin
          rpt_temp_status <= TST_HIGH_MOST;
        end else if (temp_sensed >= TEMP_DERATE) begin
          rpt_temp_status <= TST_HIGH_LEAST;
        end else if (temp_sensed < TEMP_LOW) begin
          rpt_temp_status <= TST_LOW_LEAST;
        end else begin
          rpt_temp_status <= TST_IN_RANGE;
        end
      end
      if (overtemp) begin
        rpt_fmi <= FMI_OVERTEMP;
      end else if (demand_all_failed) begin
        rpt_fmi <= FMI_DEMAND_LOST;
      end else if (temp_sensor_failed) begin
        rpt_fmi <= FMI_TSENSE_FAIL;
      end else if (pos_error) begin
        rpt_fmi <= FMI_POS_ERR;
      end else if (can_demand_out_of_range) begin
        rpt_fmi <= FMI_CAN_RANGE;
      end else if (temp_sensed >= TEMP_DERATE) begin
        rpt_fmi <= FMI_DERATE;
      end else begin
        rpt_fmi <= FMI_NORMAL;
      end
    end
  end

  // interrupt status: set wins over write-one-to-clear
  assign irq_event[IRQ_SPRING_DONE] = (spr_reg != SPR_DONE_OK) && (spr_next == SPR_DONE_OK);
  assign irq_event[IRQ_SPRING_FAIL] = (spr_reg != SPR_DONE_BAD) && (spr_next == SPR_DONE_BAD);
  assign irq_event[IRQ_OVERTEMP] = overtemp;
  assign irq_event[IRQ_CLAIM_FAIL] = addr_claim_failed;

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat_reg <= '0;
    end else if (wr_en && paddr == OFS_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule
`default_nettype wire

// File: test/adsc_assertions.sv
/*
  Checker for adsc_top, watching its ports only.
  Assumes the single mclk domain with the synchronous active-high srst.
*/
`timescale 1ns/1ps
`default_nettype none
module adsc_assertions
  import adsc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // spring loop
  input wire logic [7:0] pos_fb,
  input wire logic [7:0] spring_cmd_pos,
  input wire logic demand_valid,
  input wire logic forced_stop_state,
  input wire logic spring_cmd_active,
  input wire logic drive_zero,
  input wire logic spring_fault,
  // diagnostics
  input wire logic [7:0] demand_in_use,
  input wire logic demand_all_failed,
  input wire logic temp_sensor_failed,
  input wire logic signed [9:0] temp_sensed,
  input wire logic addr_claim_failed,
  input wire logic [7:0] rpt_desired_pos,
  input wire logic [7:0] rpt_temp,
  input wire logic [2:0] rpt_temp_status,
  input wire logic [4:0] rpt_fmi,
  input wire logic derate_flag,
  input wire logic claim_fail_status,
  input wire logic [7:0] can_demand_eff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic ovt;
  logic live;
  assign ovt = !temp_sensor_failed && temp_sensed >= TEMP_SHUTOFF;
  // registered checks start only from an edge the design saw out of reset
  assign live = !srst;
  property p_hot;
    live && ovt |-> drive_zero ##1 (rpt_fmi == FMI_OVERTEMP && rpt_temp_status == TST_HIGH_MOST);
  endproperty
  a_hot: assert property (p_hot) else $error("overtemp indication wrong");
  property p_tsense;
    live && temp_sensor_failed && !demand_all_failed |=> rpt_temp == DATA_NOT_AVAIL
      && rpt_temp_status == TST_ERROR && rpt_fmi == FMI_TSENSE_FAIL;
  endproperty
  a_tsense: assert property (p_tsense) else $error("sensor failure indication wrong");
  property p_lost;
    live && demand_all_failed && !ovt |=> rpt_desired_pos == DATA_NOT_AVAIL
      && rpt_fmi == FMI_DEMAND_LOST;
  endproperty
  a_lost: assert property (p_lost) else $error("demand loss indication wrong");
  property p_derate;
    live && !temp_sensor_failed && temp_sensed >= TEMP_DERATE && !ovt |=> derate_flag
      && rpt_temp_status == TST_HIGH_LEAST;
  endproperty
  a_derate: assert property (p_derate) else $error("derate indication wrong");
  property p_inuse;
    live && !demand_all_failed |=> rpt_desired_pos == $past(demand_in_use);
  endproperty
  a_inuse: assert property (p_inuse) else $error("demand in use not reported");
  property p_claim;
    addr_claim_failed |-> claim_fail_status && can_demand_eff == 8'h00;
  endproperty
  a_claim: assert property (p_claim) else $error("claim failure not applied");
  property p_limp;
    spring_cmd_active && pos_fb == spring_cmd_pos && !demand_valid && !forced_stop_state
      |=> drive_zero && !spring_cmd_active;
  endproperty
  a_limp: assert property (p_limp) else $error("no limp at start position");
  property p_abort;
    spring_cmd_active && (demand_valid || forced_stop_state) |=> !spring_cmd_active;
  endproperty
  a_abort: assert property (p_abort) else $error("spring drive not abandoned");
  property p_hold;
    spring_fault |=> spring_fault;
  endproperty
  a_hold: assert property (p_hold) else $error("spring fault not held");
  c_limp: cover property (spring_cmd_active ##1 drive_zero);
  c_fault: cover property ($rose(spring_fault));
  c_hot: cover property (ovt);
endmodule
bind adsc_top adsc_assertions i_adsc_assertions (.mclk, .srst, .pos_fb, .spring_cmd_pos,
  .demand_valid, .forced_stop_state, .spring_cmd_active, .drive_zero, .spring_fault,
  .demand_in_use, .demand_all_failed, .temp_sensor_failed, .temp_sensed, .addr_claim_failed,
  .rpt_desired_pos, .rpt_temp, .rpt_temp_status, .rpt_fmi, .derate_flag, .claim_fail_status,
  .can_demand_eff);
`default_nettype wire

// File: test/adsc_shaft_model.sv
/*
  Shaft and position loop stand-in for the spring check.
  Assumes one count of travel per moving cycle; slow halves the rate.
*/
`timescale 1ns/1ps
`default_nettype none
module adsc_shaft_model (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // from the block
  input wire logic spring_cmd_active,
  input wire logic [7:0] spring_cmd_pos,
  input wire logic drive_zero,
  // bench controls
  input wire logic [7:0] rest_pos,
  input wire logic slow,
  input wire logic stuck,
  // shaft
  output logic [7:0] pos_fb
);
  logic [7:0] tgt;
  logic phase_reg;
  assign tgt = spring_cmd_active ? spring_cmd_pos : rest_pos;
  always_ff @(posedge mclk) begin
    if (srst) begin
      pos_fb <= 8'h40;
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      // a limp shaft springs back toward rest; a stuck one stays put
      if ((spring_cmd_active || drive_zero) && !stuck && (!slow || phase_reg)) begin
        pos_fb <= (pos_fb < tgt) ? pos_fb + 8'h01 : (pos_fb > tgt) ? pos_fb - 8'h01 : pos_fb;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/adsc_top_test.sv
/*
  Self-checking bench for adsc_top with a shaft model on the position loop.
  Assumes the zero-wait APB slave and diagnostics registered one cycle late.
*/
`timescale 1ns/1ps
`default_nettype none
module adsc_top_test;
  import adsc_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic pready, pslverr, err, slow = 1'b0, stuck = 1'b0;
  logic pos_ctrl_active = 1'b0, demand_valid = 1'b0, forced_stop_state = 1'b0;
  logic demand_all_failed = 1'b0, analog_fail_high = 1'b0, analog_fail_low = 1'b0;
  logic pwm_fail_high = 1'b0, pwm_fail_low = 1'b0, can_demand_out_of_range = 1'b0;
  logic pos_error = 1'b0, temp_sensor_failed = 1'b0, addr_claim_failed = 1'b0;
  logic signed [9:0] temp_sensed = 10'sd25;
  logic [7:0] demand_in_use = 8'h00, can_demand_raw = 8'h00, pos_fb, spring_cmd_pos;
  logic [7:0] rpt_desired_pos, rpt_pos_fb, rpt_temp, can_demand_eff;
  logic [2:0] rpt_temp_status;
  logic [4:0] rpt_fmi;
  logic spring_cmd_active, drive_zero, derate_flag, temp_low_flag, spring_fault;
  logic claim_fail_status, irq;
  int miscompares = 0, cmp_count = 0;
  integer seed = 32'h85edb017;
  logic [11:0] adr [8] = '{OFS_CTRL, OFS_START_POS, OFS_FINISH_POS, OFS_FINISH_TMO,
    OFS_SPRING_STAT, OFS_IRQ_STAT, OFS_IRQ_MASK, 12'h020};
  logic [31:0] rv [8] = '{32'h0, {24'h0, START_POS_RST}, {24'h0, FINISH_POS_RST},
    {16'h0, FINISH_TMO_RST}, 32'h0, 32'h0, 32'h0, 32'h0};
  logic signed [9:0] tmp [8] = '{10'sd125, 10'sd124, 10'sd118, 10'sd117, -10'sd40,
    -10'sd41, 10'sd25, 10'sd300};
  always #25 mclk = ~mclk;
  adsc_top i_adsc_top (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pos_ctrl_active, .pos_fb, .demand_in_use, .demand_valid,
    .forced_stop_state, .spring_cmd_active, .spring_cmd_pos, .drive_zero, .demand_all_failed,
    .analog_fail_high, .analog_fail_low, .pwm_fail_high, .pwm_fail_low,
    .can_demand_out_of_range, .pos_error, .temp_sensor_failed, .temp_sensed,
    .addr_claim_failed, .can_demand_raw, .rpt_desired_pos, .rpt_pos_fb, .rpt_temp,
    .rpt_temp_status, .rpt_fmi, .derate_flag, .temp_low_flag, .spring_fault,
    .claim_fail_status, .can_demand_eff, .irq);
  adsc_shaft_model i_adsc_shaft_model (.mclk, .srst, .spring_cmd_active, .spring_cmd_pos,
    .drive_zero, .rest_pos(FINISH_POS_RST), .slow, .stuck, .pos_fb);
  // wide enough for a status bit or two packed above a full data word
  task chk(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rst;
    srst <= 1'b1;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
  endtask
  task spring(input logic [1:0] exp);
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_SPRING_STAT, 32'h0);
      k++;
    end while (rd[1:0] == SPR_PENDING && k < 12000);
    chk(rd, {30'h0, exp});
  endtask
  // packs drive_zero and every registered indication but rpt_pos_fb, in the order checked
  function automatic logic [31:0] diag_exp();
    logic o, d, l;
    logic [4:0] f;
    logic [2:0] s;
    o = !temp_sensor_failed && temp_sensed >= TEMP_SHUTOFF;
    d = !temp_sensor_failed && temp_sensed >= TEMP_DERATE;
    l = !temp_sensor_failed && temp_sensed < TEMP_LOW;
    f = o ? FMI_OVERTEMP : demand_all_failed ? FMI_DEMAND_LOST : temp_sensor_failed ?
      FMI_TSENSE_FAIL : pos_error ? FMI_POS_ERR : can_demand_out_of_range ? FMI_CAN_RANGE :
      d ? FMI_DERATE : FMI_NORMAL;
    s = temp_sensor_failed ? TST_ERROR : o ? TST_HIGH_MOST : d ? TST_HIGH_LEAST :
      l ? TST_LOW_LEAST : TST_IN_RANGE;
    return {o, 5'h00, f, s, demand_all_failed ? DATA_NOT_AVAIL : demand_in_use,
      temp_sensor_failed ? DATA_NOT_AVAIL : temp_sensed[7:0], d, l};
  endfunction
  initial begin
    #3000000;
    miscompares++;
    close_out();
  end
  initial begin
    int i;
    logic [31:0] e;
    logic [7:0] pe;
    logic [7:0] sp;
    rst();
    for (i = 0; i < 8; i++) begin
      apb(1'b0, adr[i], 32'h0);
      chk({err, rd}, {i == 7, rv[i]});
    end
    pos_ctrl_active <= 1'b1;
    for (i = 0; i < 300; i++) begin
      @(posedge mclk);
      r = $random(seed) & $random(seed);
      {demand_all_failed, analog_fail_high, analog_fail_low, pwm_fail_high, pwm_fail_low,
        can_demand_out_of_range, pos_error, temp_sensor_failed, addr_claim_failed} <= r[8:0];
      demand_in_use <= r[31:24];
      can_demand_raw <= r[23:16] ^ r[15:8];
      temp_sensed <= tmp[r[14:12]];
      #1;
      e = diag_exp();
      pe = pos_fb;
      @(posedge mclk);
      #1;
      chk({drive_zero, 5'h00, rpt_fmi, rpt_temp_status, rpt_desired_pos, rpt_temp,
        derate_flag, temp_low_flag}, e);
      chk({rpt_pos_fb, claim_fail_status, can_demand_eff}, {pe, addr_claim_failed,
        addr_claim_failed ? 8'h00 : can_demand_raw});
    end
    @(posedge mclk);
    {demand_all_failed, pos_error, temp_sensor_failed, addr_claim_failed} <= 4'h0;
    {analog_fail_high, analog_fail_low, pwm_fail_high, pwm_fail_low} <= 4'h0;
    can_demand_out_of_range <= 1'b0;
    temp_sensed <= 10'sd25;
    apb(1'b0, OFS_SPRING_STAT, 32'h0);
    chk({spring_cmd_active, rd}, {1'b0, 30'h0, SPR_PENDING});
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({irq, rd}, 33'h0000000c);
    apb(1'b1, OFS_IRQ_MASK, 32'h4);
    // the mask lands at the access edge; let it settle before looking
    #1;
    chk(irq, 1'b1);
    apb(1'b1, OFS_IRQ_STAT, 32'h4);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({irq, rd}, 33'h00000008);
    // passing check with a random start and shaft speed
    rst();
    r = $random(seed);
    sp = 8'h80 | r[6:0];
    slow <= r[7];
    apb(1'b1, OFS_START_POS, {24'h0, sp});
    apb(1'b1, OFS_FINISH_TMO, 32'h2);
    apb(1'b1, OFS_IRQ_MASK, 32'h3);
    apb(1'b1, OFS_CTRL, 32'h1);
    chk(spring_cmd_pos, sp);
    spring(SPR_PASSED);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({irq, rd}, 33'h100000001);
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    #1;
    chk(irq, 1'b0);
    pos_ctrl_active <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h1);
    pos_ctrl_active <= 1'b1;
    repeat (50) @(posedge mclk);
    apb(1'b0, OFS_SPRING_STAT, 32'h0);
    chk({spring_cmd_active, rd}, {1'b0, 30'h0, SPR_PASSED});
    // shaft jams once limp, so the finish timeout runs out
    rst();
    apb(1'b1, OFS_FINISH_TMO, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h1);
    for (i = 0; i < 3000 && drive_zero !== 1'b1; i++) @(posedge mclk);
    stuck <= 1'b1;
    spring(SPR_FAILED);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({irq, spring_fault, rd}, 34'h100000002);
    stuck <= 1'b0;
    // valid demand or shutdown during the drive abandons the check
    rst();
    apb(1'b1, OFS_CTRL, 32'h1);
    for (i = 0; i < 100 && spring_cmd_active !== 1'b1; i++) @(posedge mclk);
    r = $random(seed);
    {demand_valid, forced_stop_state} <= r[0] ? 2'b10 : 2'b01;
    spring(SPR_NOT_DONE);
    close_out();
  end
endmodule
`default_nettype wire
